// *** acq_partner.sv ***
// Acquisition side model: hold switch and word capture on ready.
// Assumes ready and digits come from the port under test.
`timescale 1ns/10ps
module acq_partner (
  // Clock
  input  wire logic        clock,
  // Test command
  input  wire logic        hold_req,
  // Port outputs
  input  wire logic [23:0] bcd_digits,
  input  wire logic        data_ready,
  // Hold line and captured word
  output logic             output_hold,
  output logic      [23:0] word,
  output logic             word_seen
);
  logic ready_q;
  initial output_hold = 1'b0;
  // Capture on every cycle that ready is high; word_seen flags ready rising
  always @(posedge clock) begin
    ready_q     <= data_ready;
    word_seen   <= data_ready && !ready_q;
    word        <= data_ready ? bcd_digits : word;
    output_hold <= hold_req;
  end
endmodule

// *** bcd_port_pkg.sv ***
// Constants and types for the pressure port: digit output and analog setpoint.
// Assumes one 200 MHz clock and a synchronous active-high reset.
package bcd_port_pkg;
  localparam int unsigned DIGITS           = 6;
  localparam int unsigned DIGIT_W          = 4;
  localparam int unsigned BCD_W            = 24;
  localparam int unsigned COUNT_W          = 17;
  localparam logic [16:0] COUNT_FULL       = 17'h186a0;  // 100000 counts
  localparam logic [11:0] STEP_MAX         = 12'hfa0;    // 4000 steps
  localparam logic [11:0] STEP_HALF        = 12'h7d0;    // 2000 steps, bipolar zero
  localparam logic [16:0] COUNT_PER_STEP   = 17'h019;    // 25 counts = 0.025 % FS
  localparam int unsigned CLOCK_HZ         = 200000000;
  localparam int unsigned REFRESH_MS       = 1000;
  localparam int unsigned REFRESH_CYCLES   = CLOCK_HZ / 1000 * REFRESH_MS;
  localparam int unsigned SETTLE_CYCLES    = 1;          // ready low while digits move
  localparam logic [1:0]  RESET_SOURCE_SEL = 2'h0;

  // Setpoint source selection, cycled by the menu keys
  typedef enum logic [1:0] {
    keypad_setpoint_source,
    rate_setpoint_source,
    analog_setpoint_source
  } source_t;

  // Output update sequence
  typedef enum logic [1:0] {
    out_idle,
    out_load,
    out_settle
  } out_state_t;

  // Negate a 16-bit value: invert every bit, add one, drop the carry
  function automatic logic [15:0] negate16(input logic [15:0] v);
    logic [16:0] sum;
    sum = {1'b0, ~v} + 17'h00001;
    return sum[15:0];
  endfunction
endpackage

// *** bcd_port_properties.sv ***
// Checker for the pressure port outputs.
// Assumes a bind onto bcd_pressure_port; one clock, sync reset.
`timescale 1ns/10ps
module bcd_port_properties (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // Digit side
  input wire logic        output_hold,
  input wire logic [23:0] bcd_digits,
  input wire logic        data_ready,
  // Setpoint side
  input wire logic        control_mode,
  input wire logic [16:0] control_point,
  input wire logic        control_negative,
  input wire logic [15:0] control_word,
  input wire logic        point_updated,
  input wire logic        analog_active
);
  logic [5:0] held;
  logic       nib_ok;
  // Hold length; an update already in flight may still land early on
  always_ff @(posedge clock) begin
    if (reset || !output_hold)
      held <= 6'h00;
    else if (held != 6'h3f)
      held <= held + 6'h01;
  end
  // Every nibble a decimal digit
  always_comb begin
    nib_ok = 1'b1;
    for (int i = 0; i < 6; i++)
      if (bcd_digits[4*i +: 4] > 4'h9)
        nib_ok = 1'b0;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence ready_gap;
    !data_ready ##1 data_ready;
  endsequence
  sequence quiet_gap;
    !point_updated [*8];
  endsequence
  ready_low_a: assert property ($fell(data_ready) |=> ready_gap)
    else $error("ready low not two cycles");
  digits_move_a: assert property ($changed(bcd_digits) |-> !data_ready)
    else $error("digits moved with ready high");
  digit_range_a: assert property (nib_ok && bcd_digits <= 24'h100000)
    else $error("digit word out of range");
  hold_freeze_a: assert property (held >= 6'h1e |-> $stable(bcd_digits))
    else $error("digits moved under hold");
  release_a: assert property ($fell(output_hold) |-> ##[1:40] $fell(data_ready))
    else $error("no refresh after hold release");
  analog_mode_a: assert property (analog_active |-> $past(control_mode))
    else $error("analog active outside control");
  negate_word_a: assert property (control_negative && control_point < 17'h10000
    |-> control_word == 16'(~control_point[15:0] + 16'h0001))
    else $error("negative word not negated");
  refresh_gap_a: assert property (point_updated && analog_active |=> quiet_gap)
    else $error("analog refresh too soon");
endmodule

// *** bcd_pressure_port.sv ***
// Rear accessory port: BCD pressure output with ready and hold, and analog setpoint path.
// Assumes the measured count and the digitised analog code are synchronous to clock.
//
// Operation
// - Twenty-four lines carry six BCD digits, count 0 through 100000.
// - Count scales linearly; 100000 is full scale, zero is minimum pressure.
// - Only the bare count; no range flags, decimal point or units.
// - Digit lines active high, tracking the latest pressure unless held.
// - Ready low during any digit update, high once all digits valid.
// - Hold freezes digit lines at their value and ignores new measurements.
// - On hold release, digits refresh at once to the current pressure; here to the last count taken before the hold.
// - Digit outputs always active, regardless of bus activity or menus.
// - Analog setpoint followed only when selected and in control mode.
// - Keypad setpoint entries ignored while analog source active in control.
// - Analog setpoint quantised to 4000 steps of 0.025 % full scale.
// - Analog control point and shown setpoint refresh about once a second.
// - Out-of-limit analog setpoint discarded; last in-limit point kept.
// - Bipolar unit maps lowest input to negative, highest to positive full scale.
// - Source cycles keypad, rate, analog; menu reopens on last shown choice.
// - In control mode, show whether keypad or analog source is active.
// - Sixteen-bit negation inverts all bits, adds one, drops the carry.
`timescale 1ns/10ps
module bcd_pressure_port #(
  parameter int unsigned REFRESH_COUNT = bcd_port_pkg::REFRESH_CYCLES
) (
  // Clock and reset
  input  wire logic                              clock,
  input  wire logic                              reset,
  // Measured pressure, already scaled to 0..100000 counts
  input  wire logic [bcd_port_pkg::COUNT_W-1:0]  measured_count,
  input  wire logic                              measured_valid,
  // Acquisition side
  input  wire logic                              output_hold,
  output logic      [bcd_port_pkg::BCD_W-1:0]    bcd_digits,
  output logic                                   data_ready,
  // Menu and mode
  input  wire logic                              menu_enter,
  input  wire logic                              menu_next,
  input  wire logic                              menu_leave,
  input  wire logic                              control_mode,
  input  wire logic                              bipolar_unit,
  // Keypad setpoint entry
  input  wire logic [bcd_port_pkg::COUNT_W-1:0]  keypad_point,
  input  wire logic                              keypad_write,
  // Analog code, 0..4000 steps of 2.5 mV
  input  wire logic [11:0]                       analog_code,
  // Control limits in counts
  input  wire logic [bcd_port_pkg::COUNT_W-1:0]  limit_min,
  input  wire logic [bcd_port_pkg::COUNT_W-1:0]  limit_max,
  // Control point and indications
  output logic      [bcd_port_pkg::COUNT_W-1:0]  control_point,
  output logic                                   control_negative,
  output logic      [15:0]                       control_word,
  output logic                                   point_updated,
  output logic      [1:0]                        shown_source,
  output logic                                   analog_active
);
  typedef struct packed {
    logic                             hold_meta;
    logic                             hold_sync;
    logic                             hold_last;
    bcd_port_pkg::out_state_t         out_state;
    logic                             conv_start;
    logic [bcd_port_pkg::COUNT_W-1:0] latest;
    logic                             fresh;
    logic [bcd_port_pkg::BCD_W-1:0]   digits;
    logic                             ready;
    bcd_port_pkg::source_t            selected;
    bcd_port_pkg::source_t            shown;
    logic                             in_menu;
    logic [27:0]                      tick;
    logic [bcd_port_pkg::COUNT_W-1:0] point;
    logic                             negative;
    logic [15:0]                      word;
    logic                             updated;
    logic                             active;
  } port_t;

  port_t state;
  port_t next_state;

  logic                             conv_done;
  logic [bcd_port_pkg::BCD_W-1:0]   conv_digits;
  logic [bcd_port_pkg::COUNT_W-1:0] clipped;
  logic [11:0]                      step_mag;
  logic                             step_neg;
  logic [16:0]                      product;
  logic [bcd_port_pkg::COUNT_W-1:0] scaled;
  logic                             in_limit;
  logic                             analog_on;

  // Clamp measurement to the documented count range
  assign clipped = (measured_count > bcd_port_pkg::COUNT_FULL) ?
                   bcd_port_pkg::COUNT_FULL : measured_count;

  // Converter turns the latest count into packed digits
  bin_to_bcd u_conv (
    .clock  (clock),
    .reset  (reset),
    .start  (state.conv_start),
    .value  (state.latest),
    .done   (conv_done),
    .digits (conv_digits)
  );

  // Step count: unipolar 0..4000, bipolar offset from midscale
  always_comb begin
    logic [11:0] code;
    code = (analog_code > bcd_port_pkg::STEP_MAX) ? bcd_port_pkg::STEP_MAX : analog_code;
    if (bipolar_unit && code < bcd_port_pkg::STEP_HALF) begin
      step_neg = 1'b1;
      step_mag = bcd_port_pkg::STEP_HALF - code;
    end else if (bipolar_unit) begin
      step_neg = 1'b0;
      step_mag = code - bcd_port_pkg::STEP_HALF;
    end else begin
      step_neg = 1'b0;
      step_mag = code;
    end
  end

  // Each step is 25 counts; bipolar halves span double the count per step
  assign product  = 17'(step_mag) * bcd_port_pkg::COUNT_PER_STEP;
  assign scaled   = bipolar_unit ? {product[15:0], 1'b0} : product;
  assign in_limit = step_neg ? 1'b0 == 1'b1 || (scaled <= limit_min)
                             : (scaled >= limit_min) && (scaled <= limit_max);
  assign analog_on = control_mode && (state.selected == bcd_port_pkg::analog_setpoint_source);

  // Next state of the whole port
  always_comb begin
    next_state            = state;
    next_state.conv_start = 1'b0;
    next_state.updated    = 1'b0;
    // Two-stage hold synchroniser; only the second stage is looked at
    next_state.hold_meta  = output_hold;
    next_state.hold_sync  = state.hold_meta;
    next_state.hold_last  = state.hold_sync;

    // Capture measurements only while not held
    if (measured_valid && !state.hold_sync) begin
      next_state.latest = clipped;
      next_state.fresh  = 1'b1;
    end
    // A release seen mid-update is kept as pending work, not lost
    if (state.hold_last && !state.hold_sync) begin
      next_state.fresh = 1'b1;
    end

    // Output sequence: ready drops before digits move, rises after
    case (state.out_state)
      bcd_port_pkg::out_idle: begin
        if (!state.hold_sync && (state.fresh || (state.hold_last && !state.hold_sync))) begin
          next_state.conv_start = 1'b1;
          // A sample landing now stays pending, so the set wins over the clear
          next_state.fresh      = measured_valid && !state.hold_sync;
          next_state.out_state  = bcd_port_pkg::out_load;
        end
      end
      bcd_port_pkg::out_load: begin
        if (conv_done) begin
          next_state.ready     = 1'b0;
          next_state.out_state = bcd_port_pkg::out_settle;
        end
      end
      bcd_port_pkg::out_settle: begin
        // Digits change while ready is already low; a hold arriving here still
        // completes the word so no partial value is latched
        next_state.digits    = conv_digits;
        next_state.out_state = bcd_port_pkg::out_idle;
      end
      default: begin
        next_state.out_state = bcd_port_pkg::out_idle;
      end
    endcase
    if (state.out_state == bcd_port_pkg::out_idle && !state.ready &&
        !next_state.conv_start) begin
      next_state.ready = 1'b1;
    end

    // Menu: cycles three sources, reopens on whatever was last shown
    if (menu_enter) begin
      next_state.in_menu = 1'b1;
    end else if (state.in_menu && menu_next) begin
      case (state.shown)
        bcd_port_pkg::keypad_setpoint_source: next_state.shown = bcd_port_pkg::rate_setpoint_source;
        bcd_port_pkg::rate_setpoint_source:   next_state.shown = bcd_port_pkg::analog_setpoint_source;
        default:                              next_state.shown = bcd_port_pkg::keypad_setpoint_source;
      endcase
    end else if (state.in_menu && menu_leave) begin
      next_state.in_menu  = 1'b0;
      next_state.selected = state.shown;
    end

    // Refresh tick for the analog-derived control point
    if (state.tick >= 28'(REFRESH_COUNT - 1)) begin
      next_state.tick = '0;
    end else begin
      next_state.tick = state.tick + 28'h0000001;
    end

    // Setpoint: analog once a second, keypad only when analog is off
    if (analog_on) begin
      if (state.tick == '0) begin
        next_state.updated = 1'b1;
        if (in_limit) begin
          next_state.point    = scaled;
          next_state.negative = step_neg;
          next_state.word     = step_neg ? bcd_port_pkg::negate16(scaled[15:0]) : scaled[15:0];
        end // out-of-limit keeps prior point
      end
    end else if (keypad_write) begin
      next_state.point    = keypad_point;
      next_state.negative = 1'b0;
      next_state.word     = keypad_point[15:0];
      next_state.updated  = 1'b1;
    end
    next_state.active = analog_on;
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      state          <= '0;
      state.selected <= bcd_port_pkg::keypad_setpoint_source;
      state.shown    <= bcd_port_pkg::keypad_setpoint_source;
      state.ready    <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state register
  assign bcd_digits       = state.digits;
  assign data_ready       = state.ready;
  assign control_point    = state.point;
  assign control_negative = state.negative;
  assign control_word     = state.word;
  assign point_updated    = state.updated;
  assign shown_source     = state.shown;
  assign analog_active    = state.active;
endmodule

// *** bcd_pressure_port_bench.sv ***
// Bench for the pressure port: digit output, hold and analog setpoint.
// Assumes package, port, converter, partner and checker compiled first.
`timescale 1ns/10ps
`define CHK(what, exp, got) \
  begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module bcd_pressure_port_bench;
  logic        clock = 1'b0, reset = 1'b1, measured_valid = 1'b0, hold_req = 1'b0;
  logic [16:0] measured_count = 17'h00000, keypad_point = 17'h00007;
  logic [16:0] limit_min = 17'h00000, limit_max = 17'h186a0, control_point;
  logic [16:0] edge_v[3] = '{17'h00000, 17'h186a0, 17'h1869f};
  logic [11:0] analog_code = 12'h000, rnd;
  logic        menu_enter = 1'b0, menu_next = 1'b0, menu_leave = 1'b0;
  logic        keypad_write = 1'b0, control_mode = 1'b0, bipolar_unit = 1'b0;
  logic        output_hold, data_ready, control_negative, point_updated;
  logic        analog_active, word_seen;
  logic [23:0] bcd_digits, word, last, exp_v;
  logic [15:0] control_word;
  logic [1:0]  shown_source;
  logic [23:0] exp_q[$];
  int          err_total = 0, n_compared = 0, cycles = 0;
  always #2.5 clock = ~clock;
  // Short refresh tick keeps the analog runs brief
  bcd_pressure_port #(.REFRESH_COUNT(50)) u_bcd_pressure_port (.clock(clock), .reset(reset),
    .measured_count(measured_count), .measured_valid(measured_valid),
    .output_hold(output_hold), .bcd_digits(bcd_digits), .data_ready(data_ready),
    .menu_enter(menu_enter), .menu_next(menu_next), .menu_leave(menu_leave),
    .control_mode(control_mode), .bipolar_unit(bipolar_unit), .keypad_point(keypad_point),
    .keypad_write(keypad_write), .analog_code(analog_code), .limit_min(limit_min),
    .limit_max(limit_max), .control_point(control_point), .control_negative(control_negative),
    .control_word(control_word), .point_updated(point_updated),
    .shown_source(shown_source), .analog_active(analog_active));
  acq_partner u_acq_partner (.clock(clock), .hold_req(hold_req), .bcd_digits(bcd_digits),
    .data_ready(data_ready), .output_hold(output_hold), .word(word), .word_seen(word_seen));
  function automatic logic [23:0] to_bcd(input int c);
    logic [23:0] r;
    r = 24'h000000;
    for (int i = 0; i < 6; i++) begin
      r[4*i +: 4] = 4'(c % 10);
      c = c / 10;
    end
    return r;
  endfunction
  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
    @(negedge clock);
  endtask
  task automatic measure(input logic [16:0] c, input bit keep);
    measured_count = c;
    measured_valid = 1'b1;
    @(negedge clock);
    measured_valid = 1'b0;
    if (keep) begin
      last = to_bcd(int'(c));
      exp_q.push_back(last);
    end
  endtask
  // Bounded wait for every noted word to appear
  task automatic drain();
    for (int i = 0; i < 80 && exp_q.size() != 0; i++) @(negedge clock);
    `CHK("pending", 0, exp_q.size())
    repeat (2) @(negedge clock);
  endtask
  // Two refresh pulses, so the new code is surely taken
  task automatic settle_point(input logic [11:0] code);
    analog_code = code;
    repeat (2) begin
      for (int i = 0; i < 200 && point_updated !== 1'b1; i++) @(negedge clock);
      @(negedge clock);
    end
  endtask
  // Watchdog and result watcher
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      tally_and_finish();
    end
    if (word_seen === 1'b1) begin
      exp_v = exp_q.size() != 0 ? exp_q.pop_front() : 24'hxxxxxx;
      `CHK("digits", exp_v, word)
    end
  end
  initial begin
    void'($urandom(97));
    repeat (16) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    for (int i = 0; i < 6; i++) begin
      measure(i < 3 ? edge_v[i] : 17'($urandom % 100001), 1'b1);
      drain();
    end
    hold_req = 1'b1;
    repeat (5) @(negedge clock);
    measure(17'h03039, 1'b0);
    repeat (40) @(negedge clock);
    `CHK("held", last, bcd_digits)
    hold_req = 1'b0;
    exp_q.push_back(last);
    drain();
    control_mode = 1'b1;
    pulse(keypad_write);
    `CHK("keypad", 17'h00007, control_point)
    `CHK("inactive", 1'b0, analog_active)
    pulse(menu_enter);
    pulse(menu_next);
    pulse(menu_next);
    pulse(menu_leave);
    `CHK("source", bcd_port_pkg::analog_setpoint_source, shown_source)
    `CHK("active", 1'b1, analog_active)
    pulse(menu_enter);
    `CHK("reopen", bcd_port_pkg::analog_setpoint_source, shown_source)
    pulse(menu_leave);
    rnd = 12'($urandom % 2001);
    settle_point(12'hfa0);
    `CHK("full", 17'h186a0, control_point)
    settle_point(rnd);
    `CHK("step", 17'(rnd * 25), control_point)
    pulse(keypad_write);
    `CHK("ignored", 17'(rnd * 25), control_point)
    limit_max = 17'h0c350;
    settle_point(12'hfa0);
    `CHK("limit", 17'(rnd * 25), control_point)
    bipolar_unit = 1'b1;
    limit_min = 17'h186a0;
    limit_max = 17'h186a0;
    settle_point(12'h3e8);
    `CHK("neg", 1'b1, control_negative)
    `CHK("mag", 17'h0c350, control_point)
    `CHK("word", 16'h3cb0, control_word)
    settle_point(12'hfa0);
    `CHK("pos", 17'h186a0, control_point)
    tally_and_finish();
  end
endmodule
bind bcd_pressure_port bcd_port_properties u_bcd_port_properties (.clock(clock),
  .reset(reset), .output_hold(output_hold), .bcd_digits(bcd_digits),
  .data_ready(data_ready), .control_mode(control_mode), .control_point(control_point),
  .control_negative(control_negative), .control_word(control_word),
  .point_updated(point_updated), .analog_active(analog_active));

// *** bin_to_bcd.sv ***
// Serial binary to packed BCD converter (shift and add three).
// Assumes a start pulse with the count held stable; result comes out registered.
`timescale 1ns/10ps
module bin_to_bcd (
  // Clock and reset
  input  wire logic                              clock,
  input  wire logic                              reset,
  // Request
  input  wire logic                              start,
  input  wire logic [bcd_port_pkg::COUNT_W-1:0]  value,
  // Result
  output logic                                   done,
  output logic      [bcd_port_pkg::BCD_W-1:0]    digits
);
  typedef struct packed {
    logic                             busy;
    logic [4:0]                       bit_cnt;
    logic [bcd_port_pkg::COUNT_W-1:0] shift;
    logic [bcd_port_pkg::BCD_W-1:0]   acc;
    logic                             done;
    logic [bcd_port_pkg::BCD_W-1:0]   digits;
  } conv_t;

  conv_t state;
  conv_t next_state;
  logic [bcd_port_pkg::BCD_W-1:0] adj;

  // Add three to each digit at five or above before shifting
  genvar g;
  generate
    for (g = 0; g < bcd_port_pkg::DIGITS; g++) begin : g_adj
      assign adj[g*4 +: 4] = (state.acc[g*4 +: 4] > 4'h4) ?
                             state.acc[g*4 +: 4] + 4'h3 : state.acc[g*4 +: 4];
    end
  endgenerate

  // Next state of the converter
  always_comb begin
    next_state      = state;
    next_state.done = 1'b0;
    if (start) begin
      next_state.busy    = 1'b1;
      next_state.bit_cnt = 5'h11;
      next_state.shift   = value;
      next_state.acc     = '0;
    end else if (state.busy) begin
      next_state.acc     = {adj[bcd_port_pkg::BCD_W-2:0], state.shift[16]};
      next_state.shift   = {state.shift[15:0], 1'b0};
      next_state.bit_cnt = state.bit_cnt - 5'h01;
      if (state.bit_cnt == 5'h01) begin
        next_state.busy   = 1'b0;
        next_state.done   = 1'b1;
        next_state.digits = {adj[bcd_port_pkg::BCD_W-2:0], state.shift[16]};
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign done   = state.done;
  assign digits = state.digits;
endmodule
